// [src/sync_adapter_pkg.sv]
// Shared constants and parity function for the synchronous communications adapter
package sync_adapter_pkg;
  // ----------------------------------------
  // Line control characters (7-bit codes)
  // ----------------------------------------
  localparam logic [6:0] SYN_CODE = 7'h16;
  localparam logic [6:0] SOH_CODE = 7'h01;
  localparam logic [6:0] STX_CODE = 7'h02;
  localparam logic [6:0] ETX_CODE = 7'h03;
  localparam logic [6:0] EOT_CODE = 7'h04;
  localparam logic [6:0] ETB_CODE = 7'h17;
  localparam logic [6:0] DLE_CODE = 7'h10;
  localparam logic [6:0] ENQ_CODE = 7'h05;
  localparam logic [6:0] NAK_CODE = 7'h15;
  // ----------------------------------------
  // Counts and field positions
  // ----------------------------------------
  localparam int SYNC_RUN_COUNT = 2;
  localparam int LEAD_SYN_COUNT = 6;
  localparam int CHAR_BITS = 8;
  localparam int PARITY_BIT = 7;
  localparam int CTRL_BIT = 6;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [6:0] RESET_BCC = 7'h00;
  // Odd parity bit for a 7-bit code
  function automatic logic [7:0] with_parity(input logic [6:0] c);
    with_parity = {~(^c), c};
  endfunction : with_parity
endpackage : sync_adapter_pkg

// [src/line_bit_if.sv]
// Bit-level handshake between the adapter core and its receive deframer
`timescale 1ns/10ps
interface line_bit_if;
  logic bit_tick;
  logic bit_val;
  logic [7:0] char_val;
  logic char_tick;
  logic in_phase;
  modport core (output bit_tick, output bit_val, input char_val, input char_tick, input in_phase);
  modport deframer (input bit_tick, input bit_val, output char_val, output char_tick, output in_phase);
endinterface : line_bit_if

// [src/rx_char_deframer.sv]
// Receive shift register with SYN hunt and character phase
`timescale 1ns/10ps
module rx_char_deframer
  import sync_adapter_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic hunt_i,
  // Bit stream
  line_bit_if.deframer lb
);
  typedef struct packed {
    logic [7:0] rx_reg;
    logic [2:0] bit_cnt;
    logic [1:0] syn_cnt;
    logic phase;
    logic [7:0] char_out;
    logic tick;
  } dfr_state_t;
  dfr_state_t cur_ff;
  dfr_state_t nxt_cur;

  // ----------------------------------------
  // Hunt and assemble
  // ----------------------------------------
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.tick = 1'b0;
    if (hunt_i)
    begin
      nxt_cur.phase = 1'b0;
      nxt_cur.syn_cnt = 2'd0;
      nxt_cur.bit_cnt = 3'd0;
    end
    else if (lb.bit_tick)
    begin
      nxt_cur.rx_reg = {lb.bit_val, cur_ff.rx_reg[7:1]};
      nxt_cur.bit_cnt = cur_ff.bit_cnt + 3'd1;
      if (!cur_ff.phase)
      begin
        // Before phase every bit is a candidate boundary; after first SYN check in groups of eight
        if (nxt_cur.rx_reg == with_parity(SYN_CODE) && (cur_ff.syn_cnt == 2'd0 || cur_ff.bit_cnt == 3'd7))
        begin
          nxt_cur.bit_cnt = 3'd0;
          if (cur_ff.syn_cnt == 2'(SYNC_RUN_COUNT - 1))
            nxt_cur.phase = 1'b1;
          else
            nxt_cur.syn_cnt = cur_ff.syn_cnt + 2'd1;
        end
        else if (cur_ff.syn_cnt != 2'd0 && cur_ff.bit_cnt == 3'd7)
          nxt_cur.syn_cnt = 2'd0;
      end
      else if (cur_ff.bit_cnt == 3'd7)
      begin
        nxt_cur.char_out = nxt_cur.rx_reg;
        nxt_cur.tick = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cur_ff <= '0;
    else
      cur_ff <= nxt_cur;
  end

  assign lb.char_val = cur_ff.char_out;
  assign lb.char_tick = cur_ff.tick;
  assign lb.in_phase = cur_ff.phase;
endmodule : rx_char_deframer

// [src/sync_comm_adapter.sv]
// Synchronous communications adapter core: transmit framer, receive checker
// How it works
// - Characters leave bit by bit from the transmit shift register via the send bit flop and arrive into the receive register.
// - Bit timing comes from the modem clock and character phase is declared after two consecutive SYNs.
// - A first received character after sync that is not EOT sets the error flag.
// - DLE followed by EOT is a forced disconnect and never sets the error flag.
// - SOH and the first STX of a block are kept out of the block check.
// - ETB and ETX bits are folded into the block check before it is final.
// - The block check character goes out right after ETB or ETX with nothing between.
// - Memory characters can be turned into control codes and selected control codes are detected on receive.
// - The adapter is half duplex and never sends and receives at once.
// - SYN fill is sent whenever no character is ready during transmit and no end has been requested.
// - Each transmission opens with at least six SYN characters.
// - Every sent character has odd parity and every received one is checked.
// - The block check is seven toggle bits, one per data bit, sent as the check character.
// - The receiver accumulates the same check and flags a mismatch with the received check.
// - SYN fill inside received text is dropped without touching the block.
`timescale 1ns/10ps
module sync_comm_adapter
  import sync_adapter_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Operation control
  input wire logic tx_start_i,
  input wire logic rx_start_i,
  input wire logic op_end_i,
  // Processor character in
  input wire logic tx_valid_i,
  input wire logic [6:0] tx_char_i,
  input wire logic tx_ctrl_i,
  output logic tx_ready_o,
  // Processor character out
  output logic rx_valid_o,
  output logic [6:0] rx_char_o,
  output logic rx_ctrl_o,
  output logic [7:0] status_o,
  // Modem pins
  input wire logic modem_clk_i,
  input wire logic modem_rxd_i,
  output logic send_data_o,
  output logic rts_o
);
  typedef enum {IDLE, TX_LEAD, TX_RUN, TX_BCC, RX_RUN} mode_t;
  typedef struct packed {
    logic [1:0] clk_sy;
    logic [1:0] rxd_sy;
    logic clk_last;
    mode_t mode;
    logic [7:0] tx_sr;
    logic [2:0] tx_bit;
    logic [2:0] lead_cnt;
    logic hold_full;
    logic [7:0] hold;
    logic hold_term;
    logic hold_skip;
    logic bcc_next;
    logic [6:0] bcc;
    logic in_block;
    logic send_bit;
    logic first_rx;
    logic dle_seen;
    logic expect_bcc;
    logic error;
    logic busy;
    logic rx_valid;
    logic [6:0] rx_char;
    logic rx_ctrl;
    logic end_req;
    logic last_out;
    logic tx_ready;
    logic sending;
  } core_state_t;
  core_state_t cur_ff;
  core_state_t nxt_cur;
  line_bit_if lb ();
  logic hunt;
  logic bit_edge;
  logic [6:0] rc;

  // ----------------------------------------
  // Receive deframer
  // ----------------------------------------
  assign hunt = (cur_ff.mode != RX_RUN);
  assign bit_edge = cur_ff.clk_sy[1] & ~cur_ff.clk_last;
  assign lb.bit_tick = bit_edge && cur_ff.mode == RX_RUN;
  assign lb.bit_val = cur_ff.rxd_sy[1];
  assign rc = lb.char_val[6:0];

  rx_char_deframer rx_char_deframer_i (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .hunt_i(hunt),
    .lb(lb)
  );

  // ----------------------------------------
  // Core state
  // ----------------------------------------
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.clk_sy = {cur_ff.clk_sy[0], modem_clk_i};
    nxt_cur.rxd_sy = {cur_ff.rxd_sy[0], modem_rxd_i};
    nxt_cur.clk_last = cur_ff.clk_sy[1];
    nxt_cur.rx_valid = 1'b0;
    // Hold register takes one character from the processor bus
    // Taken exactly when ready shows, so a char offered during a check char is not lost
    if (tx_valid_i && cur_ff.tx_ready)
    begin
      nxt_cur.hold = with_parity(tx_ctrl_i ? {1'b0, tx_char_i[5:0]} : tx_char_i);
      nxt_cur.hold_full = 1'b1;
      nxt_cur.hold_term = tx_char_i == ETB_CODE || tx_char_i == ETX_CODE;
      nxt_cur.hold_skip = tx_char_i == SOH_CODE || (tx_char_i == STX_CODE && !cur_ff.in_block);
    end
    case (cur_ff.mode)
      IDLE:
      begin
        // One direction at a time: a start is taken only from idle
        if (tx_start_i)
        begin
          nxt_cur.mode = TX_LEAD;
          nxt_cur.lead_cnt = 3'd0;
          nxt_cur.tx_sr = with_parity(SYN_CODE);
          nxt_cur.tx_bit = 3'd0;
          nxt_cur.error = 1'b0;
          nxt_cur.busy = 1'b1;
          nxt_cur.bcc = RESET_BCC;
          nxt_cur.in_block = 1'b0;
          nxt_cur.bcc_next = 1'b0;
          nxt_cur.end_req = 1'b0;
          nxt_cur.last_out = 1'b0;
        end
        else if (rx_start_i)
        begin
          nxt_cur.mode = RX_RUN;
          nxt_cur.error = 1'b0;
          nxt_cur.busy = 1'b1;
          nxt_cur.first_rx = 1'b1;
          nxt_cur.dle_seen = 1'b0;
          nxt_cur.expect_bcc = 1'b0;
          nxt_cur.bcc = RESET_BCC;
          nxt_cur.in_block = 1'b0;
        end
      end
      TX_LEAD, TX_RUN, TX_BCC:
      begin
        // Kept, so a short end pulse is not lost in mid-character
        if (op_end_i)
          nxt_cur.end_req = 1'b1;
        if (bit_edge)
        begin
          nxt_cur.send_bit = cur_ff.tx_sr[0];
          nxt_cur.tx_sr = {1'b1, cur_ff.tx_sr[7:1]};
          nxt_cur.tx_bit = cur_ff.tx_bit + 3'd1;
          if (cur_ff.tx_bit == 3'd7)
          begin
            if (cur_ff.mode == TX_LEAD && cur_ff.lead_cnt != 3'(LEAD_SYN_COUNT - 1))
            begin
              nxt_cur.lead_cnt = cur_ff.lead_cnt + 3'd1;
              nxt_cur.tx_sr = with_parity(SYN_CODE);
            end
            else if (cur_ff.bcc_next)
            begin
              nxt_cur.tx_sr = with_parity(cur_ff.bcc);
              nxt_cur.bcc_next = 1'b0;
              nxt_cur.bcc = RESET_BCC;
              nxt_cur.in_block = 1'b0;
              nxt_cur.mode = TX_RUN;
            end
            else if (cur_ff.hold_full)
            begin
              nxt_cur.tx_sr = cur_ff.hold;
              nxt_cur.hold_full = 1'b0;
              nxt_cur.mode = cur_ff.hold_term ? TX_BCC : TX_RUN;
              nxt_cur.bcc_next = cur_ff.hold_term;
              if (!cur_ff.hold_skip)
                nxt_cur.bcc = cur_ff.bcc ^ cur_ff.hold[6:0];
              else
                nxt_cur.in_block = 1'b1;
            end
            else if (cur_ff.end_req || op_end_i)
            begin
              // Pad of ones: the last character keeps its full final bit before send is dropped
              nxt_cur.tx_sr = 8'hff;
              nxt_cur.last_out = 1'b1;
              nxt_cur.mode = TX_RUN;
            end
            else
            begin
              nxt_cur.tx_sr = with_parity(SYN_CODE);
              nxt_cur.mode = TX_RUN;
            end
          end
          if (cur_ff.last_out)
          begin
            nxt_cur.mode = IDLE;
            nxt_cur.busy = 1'b0;
            nxt_cur.send_bit = 1'b1;
            nxt_cur.last_out = 1'b0;
            nxt_cur.end_req = 1'b0;
          end
        end
      end
      RX_RUN:
      begin
        if (lb.char_tick)
        begin
          if (^lb.char_val == 1'b0)
            nxt_cur.error = 1'b1;
          if (cur_ff.expect_bcc)
          begin
            if (rc != cur_ff.bcc)
              nxt_cur.error = 1'b1;
            nxt_cur.expect_bcc = 1'b0;
            nxt_cur.bcc = RESET_BCC;
            nxt_cur.in_block = 1'b0;
          end
          else if (rc == SYN_CODE)
            nxt_cur.bcc = cur_ff.bcc;
          else
          begin
            // A leading DLE waits for its partner; only DLE EOT may stand in place of EOT
            nxt_cur.first_rx = cur_ff.first_rx && rc == DLE_CODE && !cur_ff.dle_seen;
            if (cur_ff.first_rx && rc != EOT_CODE && !(rc == DLE_CODE && !cur_ff.dle_seen))
              nxt_cur.error = 1'b1;
            nxt_cur.dle_seen = rc == DLE_CODE;
            if (rc == SOH_CODE || (rc == STX_CODE && !cur_ff.in_block))
              nxt_cur.in_block = 1'b1;
            else if (cur_ff.in_block)
              nxt_cur.bcc = cur_ff.bcc ^ rc;
            nxt_cur.expect_bcc = cur_ff.in_block && (rc == ETB_CODE || rc == ETX_CODE);
            nxt_cur.rx_valid = 1'b1;
            nxt_cur.rx_char = rc;
            nxt_cur.rx_ctrl = rc[6:5] == 2'b00;
          end
        end
        if (op_end_i)
        begin
          nxt_cur.mode = IDLE;
          nxt_cur.busy = 1'b0;
        end
      end
      default: nxt_cur.mode = IDLE;
    endcase
    // Registered copies keep every port straight off a flop
    nxt_cur.tx_ready = nxt_cur.busy && !nxt_cur.hold_full && nxt_cur.mode != RX_RUN;
    nxt_cur.sending = nxt_cur.mode == TX_LEAD || nxt_cur.mode == TX_RUN || nxt_cur.mode == TX_BCC;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cur_ff <= '0;
      cur_ff.send_bit <= 1'b1;
      cur_ff.mode <= IDLE;
    end
    else
      cur_ff <= nxt_cur;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Ready is a flop: a character taken on the same edge clears it next cycle
  assign tx_ready_o = cur_ff.tx_ready;
  assign rx_valid_o = cur_ff.rx_valid;
  assign rx_char_o = cur_ff.rx_char;
  assign rx_ctrl_o = cur_ff.rx_ctrl;
  assign status_o = {cur_ff.busy, 6'h00, cur_ff.error};
  assign send_data_o = cur_ff.send_bit;
  assign rts_o = cur_ff.sending;
endmodule : sync_comm_adapter

// [verif/sync_comm_adapter_sva.sv]
// Port checker for the adapter
`timescale 1ns/10ps
module sync_comm_adapter_sva
  import sync_adapter_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire logic tx_start_i,
  input wire logic rx_start_i,
  input wire logic modem_clk_i,
  input wire logic rx_valid_o,
  input wire logic [6:0] rx_char_o,
  input wire logic rx_ctrl_o,
  input wire logic [7:0] status_o,
  input wire logic send_data_o,
  input wire logic rts_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ------
  // Core cycles since the raw modem clock rose, saturating
  // ------
  logic mclk_ff;
  logic [3:0] age_ff;
  always_ff @(posedge core_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      mclk_ff <= 1'b0;
      age_ff <= 4'hf;
    end
    else
    begin
      mclk_ff <= modem_clk_i;
      age_ff <= (modem_clk_i && !mclk_ff) ? 4'h0 : age_ff + {3'h0, age_ff != 4'hf};
    end
  property p_half; rts_o |-> !rx_valid_o; endproperty
  a_half: assert property (p_half) else $error("delivery while sending");
  property p_idle; !rts_o [*2] |-> send_data_o; endproperty
  a_idle: assert property (p_idle) else $error("line not marking");
  property p_bit; rts_o && $fell(send_data_o) |-> age_ff <= 4'h6; endproperty
  a_bit: assert property (p_bit) else $error("bit off modem edge");
  property p_rxt; rx_valid_o |-> age_ff <= 4'ha; endproperty
  a_rxt: assert property (p_rxt) else $error("delivery off modem edge");
  property p_one; rx_valid_o |=> !rx_valid_o; endproperty
  a_one: assert property (p_one) else $error("delivery too long");
  property p_syn; rx_valid_o |-> rx_char_o != SYN_CODE; endproperty
  a_syn: assert property (p_syn) else $error("fill delivered");
  property p_ctl; rx_valid_o |-> rx_ctrl_o == (rx_char_o[6:5] == 2'b00); endproperty
  a_ctl: assert property (p_ctl) else $error("control flag wrong");
  property p_err;
    status_o[0] && !tx_start_i && !rx_start_i && !$past(tx_start_i) && !$past(rx_start_i) |=> status_o[0];
  endproperty
  a_err: assert property (p_err) else $error("error dropped");
  property p_busy; rts_o |-> status_o[7]; endproperty
  a_busy: assert property (p_busy) else $error("busy missing");
  property p_go; tx_start_i && !status_o[7] |-> ##[1:3] rts_o; endproperty
  a_go: assert property (p_go) else $error("send not begun");
  c_tx: cover property ($rose(rts_o));
  c_err: cover property ($rose(status_o[0]));
  c_ctl: cover property (rx_valid_o && rx_ctrl_o);
endmodule : sync_comm_adapter_sva
bind sync_comm_adapter sync_comm_adapter_sva sync_comm_adapter_sva_i (.core_clk_i, .rst_n_i, .tx_start_i,
  .rx_start_i, .modem_clk_i, .rx_valid_o, .rx_char_o, .rx_ctrl_o, .status_o, .send_data_o, .rts_o);

// [verif/modem_model.sv]
// Modem model: bit clock, receive feed, capture of sent bits
`timescale 1ns/10ps
module modem_model
(
  // Adapter side
  input wire logic rts_i,
  input wire logic send_data_i,
  output logic modem_clk_o,
  output logic modem_rxd_o
);
  logic run = 1'b0;
  logic txq[$];
  initial
  begin
    modem_clk_o = 1'b0;
    modem_rxd_o = 1'b1;
  end
  // Clock stands low outside frames
  always
  begin
    #62.5;
    if (run || rts_i || modem_clk_o)
      modem_clk_o = ~modem_clk_o;
  end
  // Sampled mid-cell, away from the adapter's update
  always @(negedge modem_clk_o)
    if (rts_i)
      txq.push_back(send_data_i);
  task send_byte(input logic [7:0] b);
    run = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge modem_clk_o);
      modem_rxd_o = b[i];
    end
  endtask : send_byte
  task stop;
    @(negedge modem_clk_o);
    modem_rxd_o = 1'b1;
    run = 1'b0;
  endtask : stop
endmodule : modem_model

// [verif/sync_comm_adapter_bench.sv]
// Self-checking bench for the adapter
`timescale 1ns/10ps
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin n_fail++; $display("[ERR] %s %h %h", nm, e, a); end end
module sync_comm_adapter_bench
  import sync_adapter_pkg::*;
;
  typedef logic [7:0] bq_t[$];
  logic clk = 1'b0, rst_n = 1'b0, tx_start = 1'b0, rx_start = 1'b0, op_end = 1'b0;
  logic tx_valid = 1'b0, tx_ctrl = 1'b0;
  logic [6:0] tx_char = 7'h00;
  logic tx_ready, rx_valid, rx_ctrl, sd, rts, mclk, rxd;
  logic [6:0] rx_char;
  logic [7:0] status;
  bq_t rxq;
  int n_fail = 0, n_tests = 0;
  always #2 clk = ~clk;
  always @(posedge clk)
    if (rx_valid)
      rxq.push_back({rx_ctrl, rx_char});
  sync_comm_adapter sync_comm_adapter_i (.core_clk_i(clk), .rst_n_i(rst_n), .tx_start_i(tx_start),
    .rx_start_i(rx_start), .op_end_i(op_end), .tx_valid_i(tx_valid), .tx_char_i(tx_char), .tx_ctrl_i(tx_ctrl),
    .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_char_o(rx_char), .rx_ctrl_o(rx_ctrl), .status_o(status),
    .modem_clk_i(mclk), .modem_rxd_i(rxd), .send_data_o(sd), .rts_o(rts));
  modem_model modem_model_i (.rts_i(rts), .send_data_i(sd), .modem_clk_o(mclk), .modem_rxd_o(rxd));
  function automatic logic [7:0] par(input logic [6:0] c);
    return {~(^c), c};
  endfunction : par
  task conclude;
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task go(input logic t);
    @(posedge clk);
    tx_start <= t;
    rx_start <= !t;
    @(posedge clk);
    tx_start <= 1'b0;
    rx_start <= 1'b0;
  endtask : go
  task automatic offer(input logic [6:0] c, input logic k);
    int n = 0;
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_char <= c;
    tx_ctrl <= k;
    do @(negedge clk); while (!tx_ready && n++ < 4000);
    @(posedge clk);
    tx_valid <= 1'b0;
    if (n >= 4000)
      n_fail++;
    if (n >= 4000)
      conclude;
  endtask : offer
  task automatic end_op;
    int n = 0;
    @(posedge clk);
    op_end <= 1'b1;
    do @(negedge clk); while (status[7] && n++ < 2000);
    @(posedge clk);
    op_end <= 1'b0;
    `CHK("busy", 1'b0, status[7])
    `CHK("rts", 1'b0, rts)
    if (n >= 2000)
      conclude;
  endtask : end_op
  task automatic t_tx;
    logic [7:0] w = 8'h00;
    bq_t raw, got;
    bq_t want = '{par(STX_CODE), par(7'h05), par(7'h42), par(ETX_CODE), par(7'h44)};
    int fill = 0;
    go(1'b1);
    offer(STX_CODE, 1'b0);
    offer(7'h45, 1'b1);
    cyc(800);
    offer(7'h42, 1'b0);
    offer(ETX_CODE, 1'b0);
    cyc(600);
    end_op;
    while (modem_model_i.txq.size() > 0 && modem_model_i.txq[0])
      void'(modem_model_i.txq.pop_front());
    foreach (modem_model_i.txq[i])
    begin
      w = {modem_model_i.txq[i], w[7:1]};
      if (i % 8 == 7)
        raw.push_back(w);
    end
    foreach (raw[i])
      if (i < 6) `CHK("lead", par(SYN_CODE), raw[i])
      else if (raw[i] === par(SYN_CODE))
        fill++;
      else
        got.push_back(raw[i]);
    foreach (raw[i])
      if (i > 0 && raw[i - 1] === par(ETX_CODE)) `CHK("after end", par(7'h44), raw[i])
    `CHK("fill", 1'b1, fill > 0)
    `CHK("sent count", 5, got.size())
    foreach (want[i]) `CHK("sent", want[i], got[i])
  endtask : t_tx
  task automatic rx_run(input bq_t s, input logic err, input bq_t want);
    rxq.delete();
    go(1'b0);
    foreach (s[i])
      modem_model_i.send_byte(s[i]);
    modem_model_i.stop;
    cyc(20);
    `CHK("err", err, status[0])
    end_op;
    `CHK("err kept", err, status[0])
    `CHK("count", want.size(), rxq.size())
    foreach (want[i]) `CHK("got", want[i], rxq[i])
  endtask : rx_run
  task t_block(input logic [6:0] bcc, input logic err);
    rx_run('{8'hff, par(SYN_CODE), par(SYN_CODE), par(EOT_CODE), par(STX_CODE), par(7'h41), par(SYN_CODE),
      par(7'h42), par(ETX_CODE), par(bcc)}, err, '{8'h84, 8'h82, 8'h41, 8'h42, 8'h83});
  endtask : t_block
  task t_not_eot;
    rx_run('{par(SYN_CODE), par(SYN_CODE), par(7'h41)}, 1'b1, '{8'h41});
  endtask : t_not_eot
  task t_dle_eot;
    rx_run('{par(SYN_CODE), par(SYN_CODE), par(DLE_CODE), par(EOT_CODE)}, 1'b0, '{8'h90, 8'h84});
  endtask : t_dle_eot
  task t_parity;
    rx_run('{par(SYN_CODE), par(SYN_CODE), 8'h84}, 1'b1, '{8'h84});
  endtask : t_parity
  initial
  begin
    cyc(6);
    rst_n <= 1'b1;
    cyc(2);
    t_tx;
    t_block(7'h00, 1'b0);
    t_block(7'h01, 1'b1);
    t_not_eot;
    t_dle_eot;
    t_parity;
    conclude;
  end
endmodule : sync_comm_adapter_bench
